// [shared/dio_pkg.sv]
// Purpose: Constants and types for the digital I/O channel block
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   Channel registers repeat every CH_STRIDE bytes from CH_BASE
package dio_pkg;
    localparam int          NCH          = 4;
    localparam int          CLK_HZ       = 50000000;
    localparam int          TICK_US10    = 1;        // Timebase in 0.1 ms units
    localparam int          TICK_CYC     = CLK_HZ / 10000 * TICK_US10;
    localparam int          TICKS_PER_S  = 10000;
    localparam logic [15:0] IDLE_S_RST   = 16'h02d0; // 720 seconds
    localparam logic [7:0]  A_GCTRL      = 8'h00;
    localparam logic [7:0]  A_IDLE       = 8'h04;
    localparam logic [7:0]  A_OUT        = 8'h08;
    localparam logic [7:0]  A_FAIL_LVL   = 8'h0c;
    localparam logic [7:0]  A_STAT       = 8'h10;
    localparam logic [7:0]  A_CMD        = 8'h14;
    localparam logic [7:0]  CH_BASE      = 8'h40;
    localparam logic [7:0]  CH_STRIDE    = 8'h20;
    localparam logic [4:0]  O_CFG        = 5'h00;
    localparam logic [4:0]  O_WID        = 5'h04;
    localparam logic [4:0]  O_START      = 5'h08;
    localparam logic [4:0]  O_CNT        = 5'h0c;
    localparam logic [4:0]  O_FREQ       = 5'h10;
    localparam int          B_CLR_LO     = 0;        // CMD: counter reset bits
    localparam int          B_LCLR_LO    = 4;        // CMD: latch clear bits

    typedef enum logic [2:0] {
        DIO_PLAIN  = 3'h0,
        DIO_COUNT  = 3'h1,
        DIO_RLATCH = 3'h3,
        DIO_FLATCH = 3'h2,
        DIO_FREQ   = 3'h6
    } dio_mode_t;

    typedef struct packed {
        logic      retain;
        logic      run;
        logic      filt_en;
        logic      invert;
        dio_mode_t mode;
    } dio_cfg_t;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } dio_wid_t;
endpackage : dio_pkg

// [verilog/dio_top.sv]
// Purpose: Digital input/output channels with counter, latch, frequency and fail-safe
// Assumes: Inputs synchronous to mclk_in; pready never waits
// Notes:   reset_n_in is the power cycle; nv_lost_in marks lost backup store
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Filter rejects pulses shorter than programmed widths
// - Counter mode counts each conditioned input pulse
// - Count advances only while counter started
// - Counter reset loads startup value
// - Counter uses same inversion and filter
// - Retained count survives power cycle
// - Unretained count clears after power cycle
// - Rising latch sets on low-to-high edge
// - Latch holds until host clears it
// - Falling latch sets on high-to-low edge
// - Frequency mode measures input frequency
// - Output drives host level, reads back
// - Timeout with level bit set forces high
// - Timeout with level bit clear forces low
// - Global enable gates fail-safe forcing
// - Timeout equals host idle seconds, default 720
// - Mode change discards logged data
// - Per-channel inversion of sensed input
module dio_top #(
    parameter int TICK_CYCLES = dio_pkg::TICK_CYC
) (
    input  wire logic                     mclk_in,
    input  wire logic                     reset_n_in,
    input  wire logic                     nv_lost_in,
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [7:0]               paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    input  wire logic [dio_pkg::NCH-1:0]  input_channel_in,
    output logic      [dio_pkg::NCH-1:0]  output_channel_out,
    output logic                          log_clear_out
);
    localparam int N = dio_pkg::NCH;

    dio_pkg::dio_cfg_t cfg_reg   [N];
    dio_pkg::dio_wid_t wid_reg   [N];
    logic [31:0]       start_reg [N];
    logic [31:0]       cnt_reg   [N];
    logic [31:0]       fcnt_reg  [N];
    logic [31:0]       freq_reg  [N];
    logic [15:0]       fw_reg    [N];
    logic [N-1:0]      filt_reg, prev_reg, latch_reg;
    logic [N-1:0]      out_reg, fail_lvl_reg;
    logic              fail_en_reg, expired_reg;
    logic [15:0]       idle_reg, isec_reg;
    logic [15:0]       sub_reg, gate_reg;
    logic [12:0]       tick_cnt_reg;
    logic              tick;
    logic [31:0]       rdata_next;
    logic              map_next;
    logic [N-1:0]      cond;

    wire acc   = psel_in & penable_in;
    wire wr    = acc & pwrite_in;
    wire [N-1:0] cnt_clr  = (wr && paddr_in == dio_pkg::A_CMD) ? pwdata_in[dio_pkg::B_CLR_LO +: N] : '0;
    wire [N-1:0] latch_clr = (wr && paddr_in == dio_pkg::A_CMD) ? pwdata_in[dio_pkg::B_LCLR_LO +: N] : '0;

    // Channel register hit: true when addr selects channel ch at offset off
    function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [4:0] off);
        logic [7:0] base;
        base = 8'(dio_pkg::CH_BASE + ch * dio_pkg::CH_STRIDE);
        ch_hit = (a == 8'(base + off));
    endfunction : ch_hit

    // 0.1 ms timebase; a parameter so simulation can shorten it
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in || tick_cnt_reg == 13'(TICK_CYCLES - 1))
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 13'h1;
    end
    assign tick = (tick_cnt_reg == 13'(TICK_CYCLES - 1));
    // Optional inversion ahead of all input processing
    always_comb
    begin
        for (int i = 0; i < N; i++)
            cond[i] = input_channel_in[i] ^ cfg_reg[i].invert;
    end
    // Glitch filter: a new level must hold for its own minimum width in ticks
    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!reset_n_in)
            begin
                filt_reg[i] <= 1'b0;
                fw_reg[i]   <= '0;
            end
            else if (!cfg_reg[i].filt_en || cond[i] == filt_reg[i])
            begin
                filt_reg[i] <= cond[i];
                fw_reg[i]   <= '0;
            end
            else if (fw_reg[i] >= (cond[i] ? wid_reg[i].high : wid_reg[i].low))
            begin
                filt_reg[i] <= cond[i];
                fw_reg[i]   <= '0;
            end
            else if (tick)
                fw_reg[i] <= fw_reg[i] + 16'h1;
        end
    end
    // Previous conditioned level for edge detection
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
            prev_reg <= '0;
        else
            prev_reg <= filt_reg;
    end
    // Latches: a set in the clear cycle wins so no edge is lost
    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!reset_n_in)
                latch_reg[i] <= 1'b0;
            else if (cfg_reg[i].mode == dio_pkg::DIO_RLATCH && filt_reg[i] && !prev_reg[i])
                latch_reg[i] <= 1'b1;
            else if (cfg_reg[i].mode == dio_pkg::DIO_FLATCH && !filt_reg[i] && prev_reg[i])
                latch_reg[i] <= 1'b1;
            else if (latch_clr[i])
                latch_reg[i] <= 1'b0;
        end
    end
    // Counters; reset keeps the count only when retention is on and backup held
    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!reset_n_in)
            begin
                if (nv_lost_in || !cfg_reg[i].retain)
                    cnt_reg[i] <= '0;
            end
            else if (cnt_clr[i])
                cnt_reg[i] <= start_reg[i];
            else if (cfg_reg[i].mode == dio_pkg::DIO_COUNT && cfg_reg[i].run && filt_reg[i] && !prev_reg[i])
                cnt_reg[i] <= cnt_reg[i] + 32'h1;
        end
    end
    // Frequency: rising edges counted over a one second gate, result in Hz
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in || (tick && gate_reg == 16'(dio_pkg::TICKS_PER_S - 1)))
            gate_reg <= '0;
        else if (tick)
            gate_reg <= gate_reg + 16'h1;
        for (int i = 0; i < N; i++)
        begin
            if (!reset_n_in)
            begin
                fcnt_reg[i] <= '0;
                freq_reg[i] <= '0;
            end
            else if (tick && gate_reg == 16'(dio_pkg::TICKS_PER_S - 1))
            begin
                freq_reg[i] <= (cfg_reg[i].mode == dio_pkg::DIO_FREQ) ? fcnt_reg[i] : '0;
                fcnt_reg[i] <= '0;
            end
            else if (filt_reg[i] && !prev_reg[i])
                fcnt_reg[i] <= fcnt_reg[i] + 32'h1;
        end
    end
    // Host idle watchdog; any completed bus transfer counts as host activity
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in || acc)
        begin
            sub_reg     <= '0;
            isec_reg    <= '0;
            expired_reg <= 1'b0;
        end
        else if (tick)
        begin
            if (sub_reg == 16'(dio_pkg::TICKS_PER_S - 1))
            begin
                sub_reg <= '0;
                if (isec_reg < idle_reg)
                    isec_reg <= isec_reg + 16'h1;
            end
            else
                sub_reg <= sub_reg + 16'h1;
        end
        if (reset_n_in && !acc && isec_reg >= idle_reg)
            expired_reg <= 1'b1;
    end
    // Output drive; the forced level shows in the readback too
    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!reset_n_in)
                output_channel_out[i] <= 1'b0;
            else if (fail_en_reg && expired_reg)
                output_channel_out[i] <= fail_lvl_reg[i];
            else
                output_channel_out[i] <= out_reg[i];
        end
    end
    // Register writes
    always_ff @(posedge mclk_in)
    begin
        log_clear_out <= 1'b0;
        if (!reset_n_in)
        begin
            fail_en_reg  <= 1'b0;
            idle_reg     <= dio_pkg::IDLE_S_RST;
            out_reg      <= '0;
            fail_lvl_reg <= '0;
            for (int i = 0; i < N; i++)
            begin
                if (nv_lost_in)
                    cfg_reg[i] <= '0;
                else
                    cfg_reg[i] <= dio_pkg::dio_cfg_t'({cfg_reg[i].retain, 6'h00});
                wid_reg[i]   <= '0;
                start_reg[i] <= '0;
            end
        end
        else if (wr)
        begin
            case (paddr_in)
                dio_pkg::A_GCTRL:    fail_en_reg  <= pwdata_in[0];
                dio_pkg::A_IDLE:     idle_reg     <= pwdata_in[15:0];
                dio_pkg::A_OUT:      out_reg      <= pwdata_in[N-1:0];
                dio_pkg::A_FAIL_LVL: fail_lvl_reg <= pwdata_in[N-1:0];
                default:             ;
            endcase
            for (int i = 0; i < N; i++)
            begin
                if (ch_hit(paddr_in, i, dio_pkg::O_CFG))
                begin
                    cfg_reg[i] <= dio_pkg::dio_cfg_t'(pwdata_in[6:0]);
                    if (pwdata_in[2:0] != cfg_reg[i].mode)
                        log_clear_out <= 1'b1;
                end
                if (ch_hit(paddr_in, i, dio_pkg::O_WID))
                    wid_reg[i] <= dio_pkg::dio_wid_t'(pwdata_in);
                if (ch_hit(paddr_in, i, dio_pkg::O_START))
                    start_reg[i] <= pwdata_in;
            end
        end
    end
    // Read mux; data captured in the setup cycle so pready needs no wait
    always_comb
    begin
        rdata_next = '0;
        map_next   = 1'b1;
        case (paddr_in)
            dio_pkg::A_GCTRL:    rdata_next[0]     = fail_en_reg;
            dio_pkg::A_IDLE:     rdata_next[15:0]  = idle_reg;
            dio_pkg::A_OUT:      rdata_next[N-1:0] = output_channel_out;
            dio_pkg::A_FAIL_LVL: rdata_next[N-1:0] = fail_lvl_reg;
            dio_pkg::A_STAT:     rdata_next        = {20'h0, latch_reg, filt_reg, 3'h0, expired_reg};
            dio_pkg::A_CMD:      rdata_next        = '0;
            default:             map_next          = 1'b0;
        endcase
        for (int i = 0; i < N; i++)
        begin
            if (ch_hit(paddr_in, i, dio_pkg::O_CFG))
                rdata_next = {25'h0, cfg_reg[i]};
            if (ch_hit(paddr_in, i, dio_pkg::O_WID))
                rdata_next = wid_reg[i];
            if (ch_hit(paddr_in, i, dio_pkg::O_START))
                rdata_next = start_reg[i];
            if (ch_hit(paddr_in, i, dio_pkg::O_CNT))
                rdata_next = cnt_reg[i];
            if (ch_hit(paddr_in, i, dio_pkg::O_FREQ))
                rdata_next = freq_reg[i];
            if (ch_hit(paddr_in, i, dio_pkg::O_CFG) || ch_hit(paddr_in, i, dio_pkg::O_WID) ||
                ch_hit(paddr_in, i, dio_pkg::O_START) || ch_hit(paddr_in, i, dio_pkg::O_CNT) ||
                ch_hit(paddr_in, i, dio_pkg::O_FREQ))
                map_next = 1'b1;
        end
    end
    // Bus answer registers
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end
        else if (psel_in && !penable_in)
        begin
            prdata_out  <= pwrite_in ? '0 : rdata_next;
            pslverr_out <= !map_next;
        end
    end
    assign pready_out = 1'b1;

    a_latch_rise_set: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cfg_reg[2].mode == dio_pkg::DIO_RLATCH && filt_reg[2] && !prev_reg[2] |=> latch_reg[2])
        else $error("rising latch not set");
    a_latch_fall_set: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cfg_reg[3].mode == dio_pkg::DIO_FLATCH && !filt_reg[3] && prev_reg[3] |=> latch_reg[3])
        else $error("falling latch not set");
    a_latch_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        latch_reg[2] && !latch_clr[2] |=> latch_reg[2])
        else $error("latch dropped without clear");
    a_cnt_stopped: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !cfg_reg[0].run && !cnt_clr[0] |=> $stable(cnt_reg[0]))
        else $error("stopped counter moved");
    a_cnt_reload: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cnt_clr[0] |=> cnt_reg[0] == $past(start_reg[0]))
        else $error("counter reset missed startup value");
    a_cnt_step: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cfg_reg[0].mode == dio_pkg::DIO_COUNT && cfg_reg[0].run && filt_reg[0] && !prev_reg[0] && !cnt_clr[0]
        |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h1)
        else $error("counter missed pulse");
    a_fail_force: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        fail_en_reg && expired_reg ##1 fail_en_reg && expired_reg |-> output_channel_out == $past(fail_lvl_reg))
        else $error("fail-safe level not driven");
    a_out_follow: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !(fail_en_reg && expired_reg) |=> output_channel_out == $past(out_reg))
        else $error("output forced without enable");
    a_idle_kick: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        acc |=> !expired_reg && isec_reg == 16'h0)
        else $error("host access did not restart timer");
    a_filt_glitch: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $past(cfg_reg[0].filt_en) && $changed(filt_reg[0]) |->
        $past(fw_reg[0]) >= (filt_reg[0] ? $past(wid_reg[0].high) : $past(wid_reg[0].low)))
        else $error("filter passed wrong level");
endmodule : dio_top

// [testbench/dio_host_model.sv]
// Purpose: Host controller model that issues APB transfers to the channel block
// Assumes: One transfer at a time; pready is sampled only at rising edges
// Notes:   Idle address and data carry the inverse of the last value, so stale values never look valid
`timescale 1ns/1ps
module dio_host_model (
    input  wire logic        mclk_in,
    input  wire logic        pready_in,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pslverr_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic      [7:0]  paddr_out,
    output logic      [31:0] pwdata_out
);
    // Bus idle from time zero
    initial
    begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'hff;
        pwdata_out  = 32'hffffffff;
    end

    // One setup cycle, then access until pready; the wait is bounded so a dead slave cannot hang the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic to);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= w;
        paddr_out   <= a;
        pwdata_out  <= wd;
        @(posedge mclk_in);
        penable_out <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (pready_in !== 1'b1 && n < 64);
        to          = (pready_in !== 1'b1);
        rd          = prdata_in;
        err         = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        paddr_out   <= ~a;
        pwdata_out  <= ~wd;
    endtask : xfer
endmodule : dio_host_model

// [testbench/dio_top_bench.sv]
// Purpose: Self-checking bench for the digital I/O channel block
// Assumes: Short tick (2 cycles) so one second is 20000 cycles
// Notes:   Random values come from an xorshift generator with a fixed seed
`timescale 1ns/1ps
module dio_top_bench;
    localparam int TK = 2;
    logic        mclk_in    = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        nv_lost_in = 1'b1;
    logic [3:0]  in_ch      = 4'h0;
    logic        psel, penable, pwrite, pready, pslverr, log_clear;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  out_ch;
    logic [31:0] seed       = 32'h00005431;
    int          fails = 0, samples_checked = 0, logs = 0;

    // 50 MHz clock
    always #10 mclk_in = ~mclk_in;

    dio_top #(.TICK_CYCLES(TK)) dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .nv_lost_in(nv_lost_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .input_channel_in(in_ch),
        .output_channel_out(out_ch), .log_clear_out(log_clear));

    dio_host_model host (.mclk_in(mclk_in), .pready_in(pready), .prdata_in(prdata), .pslverr_in(pslverr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));

    // Count logger-discard pulses
    always @(posedge mclk_in)
        if (log_clear === 1'b1) logs <= logs + 1;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        samples_checked++;
        if (((got >= lo) && (got <= hi)) !== 1'b1)
        begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, lo);
        end
    endtask : cmp_range

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [7:0] ch(input int i, input logic [4:0] off);
        return 8'(dio_pkg::CH_BASE + dio_pkg::CH_STRIDE * i + off);
    endfunction : ch

    // Expected frequency reading for a square wave of the given period in clock cycles
    function automatic logic [31:0] exp_hz(input int period);
        return 32'(dio_pkg::TICKS_PER_S * TK / period);
    endfunction : exp_hz

    function automatic logic [31:0] cfg(input dio_pkg::dio_mode_t m, input logic inv, input logic flt,
                                        input logic run, input logic ret);
        return {25'h0, ret, run, flt, inv, m};
    endfunction : cfg

    // Bus access; a timeout is a mismatch and ends the run
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        logic to;
        host.xfer(w, a, wd, r, e, to);
        if (to)
        begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, 32'h0, 32'h1);
            end_sim();
        end
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        acc(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        acc(1'b0, a, 32'h0, r, e);
        cmp_word(r, exp);
    endtask : rd_chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc

    // Raw input high for hc cycles, then low for lc; called right after an edge so periods stay exact
    task automatic pulse(input int k, input int hc, input int lc);
        in_ch[k] <= 1'b1;
        cyc(hc);
        in_ch[k] <= 1'b0;
        cyc(lc);
    endtask : pulse

    // Main sequence
    initial
    begin
        logic [31:0] s, r;
        logic        e;
        int          n, l0;
        cyc(4);
        reset_n_in <= 1'b1;
        nv_lost_in <= 1'b0;
        cyc(1);
        rd_chk(dio_pkg::A_IDLE, {16'h0, dio_pkg::IDLE_S_RST});
        acc(1'b0, 8'h18, 32'h0, r, e);
        cmp_word({r[30:0], e}, 32'h1);
        // Output levels follow the host and read back
        for (int i = 0; i < 4; i++)
        begin
            s = rnd() & 32'hf;
            wr(dio_pkg::A_OUT, s);
            rd_chk(dio_pkg::A_OUT, s);
            cmp_word({28'h0, out_ch}, s);
        end
        // Fail-safe: mixed levels so both forced-high and forced-low channels are seen
        wr(dio_pkg::A_OUT, 32'h9);
        wr(dio_pkg::A_FAIL_LVL, 32'h6);
        wr(dio_pkg::A_IDLE, 32'h0);
        cyc(10);
        cmp_word({28'h0, out_ch}, 32'h9);
        wr(dio_pkg::A_GCTRL, 32'h1);
        cyc(10);
        cmp_word({28'h0, out_ch}, 32'h6);
        wr(dio_pkg::A_IDLE, 32'h1);
        cyc(10);
        cmp_word({28'h0, out_ch}, 32'h9);
        cyc(18000);
        cmp_word({28'h0, out_ch}, 32'h9);
        cyc(4000);
        cmp_word({28'h0, out_ch}, 32'h6);
        wr(dio_pkg::A_GCTRL, 32'h0);
        // Filtered counter on channel 0 with glitches of both levels
        s = rnd() & 32'hffff;
        l0 = logs;
        wr(ch(0, dio_pkg::O_WID), {16'h5, 16'h4});
        wr(ch(0, dio_pkg::O_START), s);
        wr(ch(0, dio_pkg::O_CFG), cfg(dio_pkg::DIO_COUNT, 1'b0, 1'b1, 1'b1, 1'b1));
        wr(dio_pkg::A_CMD, 32'h1);
        rd_chk(ch(0, dio_pkg::O_CNT), s);
        n = int'(rnd() & 32'h7) + 1;
        repeat (n)
        begin
            pulse(0, 3, 30);
            pulse(0, 30, 3);
            pulse(0, 30, 30);
        end
        rd_chk(ch(0, dio_pkg::O_CNT), s + n);
        wr(ch(0, dio_pkg::O_CFG), cfg(dio_pkg::DIO_COUNT, 1'b0, 1'b1, 1'b0, 1'b1));
        pulse(0, 30, 30);
        rd_chk(ch(0, dio_pkg::O_CNT), s + n);
        wr(ch(0, dio_pkg::O_CFG), cfg(dio_pkg::DIO_COUNT, 1'b0, 1'b1, 1'b1, 1'b1));
        pulse(0, 30, 30);
        rd_chk(ch(0, dio_pkg::O_CNT), s + n + 1);
        cmp_word(32'(logs - l0), 32'h1);
        // Inversion on channel 1, then counting of the inverted input
        wr(ch(1, dio_pkg::O_CFG), cfg(dio_pkg::DIO_PLAIN, 1'b1, 1'b0, 1'b0, 1'b0));
        cyc(5);
        rd_chk(dio_pkg::A_STAT, 32'h20);
        wr(ch(1, dio_pkg::O_CFG), cfg(dio_pkg::DIO_COUNT, 1'b1, 1'b0, 1'b1, 1'b0));
        pulse(1, 30, 30);
        rd_chk(ch(1, dio_pkg::O_CNT), 32'h1);
        // Edge latches on channels 2 and 3
        @(posedge mclk_in) in_ch[3] <= 1'b1;
        wr(ch(2, dio_pkg::O_CFG), cfg(dio_pkg::DIO_RLATCH, 1'b0, 1'b0, 1'b0, 1'b0));
        wr(ch(3, dio_pkg::O_CFG), cfg(dio_pkg::DIO_FLATCH, 1'b0, 1'b0, 1'b0, 1'b0));
        rd_chk(dio_pkg::A_STAT, 32'h0a0);
        pulse(2, 10, 10);
        pulse(3, 10, 10);
        rd_chk(dio_pkg::A_STAT, 32'hc20);
        wr(dio_pkg::A_CMD, 32'hc0);
        rd_chk(dio_pkg::A_STAT, 32'h20);
        // Power cycle with backup store intact
        @(posedge mclk_in) reset_n_in <= 1'b0;
        cyc(4);
        reset_n_in <= 1'b1;
        cyc(1);
        rd_chk(ch(0, dio_pkg::O_CNT), s + n + 1);
        rd_chk(ch(0, dio_pkg::O_CFG), 32'h40);
        rd_chk(ch(1, dio_pkg::O_CNT), 32'h0);
        // Frequency: 100-cycle period gives 200 pulses per 20000-cycle gate
        wr(ch(2, dio_pkg::O_CFG), cfg(dio_pkg::DIO_FREQ, 1'b0, 1'b0, 1'b0, 1'b0));
        fork
            repeat (440) pulse(2, 50, 50);
            begin
                cyc(42000);
                acc(1'b0, ch(2, dio_pkg::O_FREQ), 32'h0, r, e);
                cmp_range(r, exp_hz(100) - 32'h1, exp_hz(100) + 32'h1);
            end
        join
        end_sim();
    end
endmodule : dio_top_bench
